/* hdl/ams_scan_sequencer.sv */
/*
  Scan sequencer for one shared converter core and an eight-input
  multiplexer, with its configuration serial port and register file.
  Assumes the sample clock i_mclk runs continuously and the serial
  pins come from outside its domain; the core samples on each rising edge.
*/
`timescale 1ns/100ps

// How it works
// - one channel: same input every sample
// - several channels: time-share core through mux
// - per-channel rate is full rate over N
// - channel count from 3-bit field at 0x01
// - count field zero selects all eight
// - mux follows scan list at 0x7D-0x7F
// - slots beyond count are ignored
// - sample first N entries in list order
// - slot bit positions in the 24-bit list
// - reset list is ascending 0 to 7
// - sample taken on each rising clock edge
// - output data follows sample by 28 clocks
module ams_scan_sequencer
  import ams_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_cfg_cs_n,
  input  wire logic       i_cfg_sclk,
  input  wire logic       i_cfg_sdi,
  output logic            o_cfg_sdo,
  output logic            o_cfg_sdo_oe_n,
  output logic [2:0]      o_mux_sel,
  output logic            o_sample_strobe,
  output logic            o_scan_start,
  output logic [3:0]      o_rate_div,
  output logic [2:0]      o_data_chan,
  output logic            o_data_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 select, bit 1 clock, bit 2 data
  logic [2:0]  sync1_ff, sync2_ff, sync3_ff, filt_ff, filt_q_ff;

  // Change accepted only when second and third stages agree; otherwise hold.
  // Reset to the idle levels (select high, clock and data low) so no false
  // clock edge follows reset.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sync1_ff  <= 3'h1;
      sync2_ff  <= 3'h1;
      sync3_ff  <= 3'h1;
      filt_ff   <= 3'h1;
      filt_q_ff <= 3'h1;
    end else begin
      sync1_ff  <= {i_cfg_sdi, i_cfg_sclk, i_cfg_cs_n};
      sync2_ff  <= sync1_ff;
      sync3_ff  <= sync2_ff;
      filt_ff   <= (~(sync2_ff ^ sync3_ff) & sync2_ff) | ((sync2_ff ^ sync3_ff) & filt_ff);
      filt_q_ff <= filt_ff;
    end
  end

  logic sel_act, sclk_rise, sclk_fall;
  assign sel_act   = ~filt_ff[0];
  assign sclk_rise =  filt_ff[1] & ~filt_q_ff[1];
  assign sclk_fall = ~filt_ff[1] &  filt_q_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // Serial frame: R/W bit, 7-bit address, 8-bit data, MSB first
  logic [4:0]  bit_cnt_ff;
  logic [15:0] shift_in_ff;
  logic [7:0]  shift_out_ff;
  logic [15:0] nxt_shift_in;
  logic        is_read;
  logic [7:0]  rd_data;
  logic        wr_commit;

  assign nxt_shift_in = {shift_in_ff[14:0], filt_ff[2]};
  assign is_read      = shift_in_ff[7];   // Direction bit once address is in
  assign wr_commit    = sel_act & sclk_rise & (bit_cnt_ff == FRAME_DONE - 5'h01) & ~shift_in_ff[14];

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !sel_act) begin
      bit_cnt_ff  <= 5'h00;
      shift_in_ff <= 16'h0000;
    end else if (sclk_rise && bit_cnt_ff != FRAME_DONE) begin
      bit_cnt_ff  <= bit_cnt_ff + 5'h01;
      shift_in_ff <= nxt_shift_in;
    end
  end

  // Read data loads after the address byte; shifts out on falling clock
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      shift_out_ff   <= 8'h00;
      o_cfg_sdo      <= 1'b0;
      o_cfg_sdo_oe_n <= 1'b1;
    end else if (!sel_act) begin
      o_cfg_sdo_oe_n <= 1'b1;
    end else if (bit_cnt_ff == ADDR_DONE && sclk_fall && is_read) begin
      o_cfg_sdo      <= rd_data[7];
      shift_out_ff   <= {rd_data[6:0], 1'b0};
      o_cfg_sdo_oe_n <= 1'b0;
    end else if (sclk_fall && !o_cfg_sdo_oe_n) begin
      o_cfg_sdo      <= shift_out_ff[7];
      shift_out_ff   <= {shift_out_ff[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [2:0]  chan_count_ff;
  logic [7:0]  scan_order_low_ff, scan_order_mid_ff, scan_order_high_ff;
  logic        cfg_dirty_ff;
  logic [6:0]  wr_addr;

  assign wr_addr = shift_in_ff[13:7];

  // Writes land only on a complete frame; unmapped addresses are dropped
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      chan_count_ff      <= RST_CHAN_COUNT;
      scan_order_low_ff  <= RST_SCAN_ORDER_LOW;
      scan_order_mid_ff  <= RST_SCAN_ORDER_MID;
      scan_order_high_ff <= RST_SCAN_ORDER_HI;
    end else if (wr_commit) begin
      unique case (wr_addr)
        ADDR_CHAN_COUNT:     chan_count_ff      <= nxt_shift_in[CHAN_COUNT_LSB +: CHAN_COUNT_W];
        ADDR_SCAN_ORDER_LOW: scan_order_low_ff  <= nxt_shift_in[7:0];
        ADDR_SCAN_ORDER_MID: scan_order_mid_ff  <= nxt_shift_in[7:0];
        ADDR_SCAN_ORDER_HI:  scan_order_high_ff <= nxt_shift_in[7:0];
        default: ;
      endcase
    end
  end

  // Reserved bits and unmapped addresses read as zero
  always_comb begin
    unique case (shift_in_ff[6:0])
      ADDR_CHAN_COUNT:     rd_data = {5'h00, chan_count_ff};
      ADDR_SCAN_ORDER_LOW: rd_data = scan_order_low_ff;
      ADDR_SCAN_ORDER_MID: rd_data = scan_order_mid_ff;
      ADDR_SCAN_ORDER_HI:  rd_data = scan_order_high_ff;
      default:             rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: shadow copy taken only at a scan boundary
  logic [23:0] active_order_ff;
  logic [3:0]  active_n_ff;
  logic [2:0]  slot_ff;
  logic        last_slot;

  assign last_slot = ({1'b0, slot_ff} == active_n_ff - 4'h1);

  // Dirty flag: a write in the boundary cycle still counts (set wins)
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cfg_dirty_ff <= 1'b0;
    end else begin
      cfg_dirty_ff <= wr_commit | (cfg_dirty_ff & ~last_slot);
    end
  end

  // Restart at slot 0 with new settings once the current scan ends
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      active_order_ff <= {RST_SCAN_ORDER_HI, RST_SCAN_ORDER_MID, RST_SCAN_ORDER_LOW};
      active_n_ff     <= ams_count_decode(RST_CHAN_COUNT);
      slot_ff         <= 3'h0;
    end else if (last_slot) begin
      slot_ff <= 3'h0;
      if (cfg_dirty_ff) begin
        active_order_ff <= {scan_order_high_ff, scan_order_mid_ff, scan_order_low_ff};
        active_n_ff     <= ams_count_decode(chan_count_ff);
      end
    end else begin
      slot_ff <= slot_ff + 3'h1;
    end
  end

  // Mux select and strobe: one conversion every rising edge
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mux_sel       <= 3'h0;
      o_sample_strobe <= 1'b0;
      o_scan_start    <= 1'b0;
      o_rate_div      <= 4'h8;
    end else begin
      o_mux_sel       <= ams_slot_chan(active_order_ff, slot_ff);
      o_sample_strobe <= 1'b1;
      o_scan_start    <= (slot_ff == 3'h0);
      o_rate_div      <= active_n_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel tag follows the sample through the core latency
  logic [2:0] tag_pipe_ff [CORE_LATENCY];
  logic [CORE_LATENCY-1:0] vld_pipe_ff;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      vld_pipe_ff <= '0;
      for (int i = 0; i < CORE_LATENCY; i++) tag_pipe_ff[i] <= 3'h0;
    end else begin
      vld_pipe_ff    <= {vld_pipe_ff[CORE_LATENCY-2:0], o_sample_strobe};
      tag_pipe_ff[0] <= o_mux_sel;
      for (int i = 1; i < CORE_LATENCY; i++) tag_pipe_ff[i] <= tag_pipe_ff[i-1];
    end
  end

  assign o_data_chan  = tag_pipe_ff[CORE_LATENCY-1];
  assign o_data_valid = vld_pipe_ff[CORE_LATENCY-1];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_last_slot;
    last_slot;
  endsequence

  sequence s_first_slot;
    slot_ff == 3'h0;
  endsequence

  a_scan_wrap_first: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_last_slot |=> s_first_slot) else $error("scan did not wrap to first slot");

  a_slot_in_range: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    {1'b0, slot_ff} < active_n_ff) else $error("slot beyond channel count");

  a_slot_advance: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !last_slot |=> slot_ff == $past(slot_ff) + 3'h1) else $error("slot skipped");

  a_single_chan_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (active_n_ff == 4'h1) [*2] |=> $stable(o_mux_sel)) else $error("single channel mux moved");

  a_mux_follows_list: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 o_mux_sel == ams_slot_chan($past(active_order_ff), $past(slot_ff))) else $error("mux off list");

  a_count_zero_eight: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_last_slot ##0 cfg_dirty_ff ##0 (chan_count_ff == 3'h0) |=> active_n_ff == 4'h8)
    else $error("count zero not eight");

  a_apply_at_boundary: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 ($changed(active_order_ff) || $changed(active_n_ff)) |-> $past(last_slot) && (slot_ff == 3'h0))
    else $error("config applied mid scan");

  a_tag_latency: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_data_valid |-> o_data_chan == $past(o_mux_sel, 28)) else $error("tag latency wrong");

  a_rate_divider: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 o_rate_div == $past(active_n_ff)) else $error("rate divider wrong");

  a_reset_order: assert property (@(posedge i_mclk)
    i_sys_rst |=> {scan_order_high_ff, scan_order_mid_ff, scan_order_low_ff} == 24'h8EAC78)
    else $error("reset list not ascending");

endmodule // ams_scan_sequencer

/* hdl/ams_pkg.sv */
/*
  Constants shared by the input-multiplexer scan sequencer: register
  addresses, reset values, field positions and pipeline counts.
  Assumes a single sample clock that also runs the configuration port.
*/
package ams_pkg;

  // Register addresses on the configuration serial port
  localparam logic [6:0] ADDR_CHAN_COUNT     = 7'h01;
  localparam logic [6:0] ADDR_SCAN_ORDER_LOW = 7'h7D;
  localparam logic [6:0] ADDR_SCAN_ORDER_MID = 7'h7E;
  localparam logic [6:0] ADDR_SCAN_ORDER_HI  = 7'h7F;

  // Values after reset
  localparam logic [2:0] RST_CHAN_COUNT      = 3'h0;   // All eight inputs
  localparam logic [7:0] RST_SCAN_ORDER_LOW  = 8'h78;
  localparam logic [7:0] RST_SCAN_ORDER_MID  = 8'hAC;
  localparam logic [7:0] RST_SCAN_ORDER_HI   = 8'h8E;

  // Field layout
  localparam int CHAN_COUNT_LSB = 0;
  localparam int CHAN_COUNT_W   = 3;
  localparam int SLOT_W         = 3;
  localparam int NUM_SLOTS      = 8;

  // Serial frame: one direction bit, seven address bits, eight data bits
  localparam int         FRAME_BITS = 16;
  localparam logic [4:0] ADDR_DONE  = 5'h08;
  localparam logic [4:0] FRAME_DONE = 5'h10;

  // Sample-to-output latency of the converter core, in sample clocks
  localparam int CORE_LATENCY = 28;

  // Slot positions inside the 24-bit list word {hi, mid, low}
  function automatic logic [2:0] ams_slot_chan(input logic [23:0] order,
                                               input logic [2:0]  slot);
    logic [2:0] ch;
    ch = 3'h0;
    unique case (slot)
      3'h0: ch = order[2:0];
      3'h1: ch = order[8:6];
      3'h2: ch = order[14:12];
      3'h3: ch = order[20:18];
      3'h4: ch = order[23:21];
      3'h5: ch = order[17:15];
      3'h6: ch = order[11:9];
      3'h7: ch = order[5:3];
    endcase
    return ch;
  endfunction

  // Count field to number of channels in use; zero means eight
  function automatic logic [3:0] ams_count_decode(input logic [2:0] sel);
    return (sel == 3'h0) ? 4'h8 : {1'b0, sel};
  endfunction

endpackage

/* bench/ams_core_model.sv */
/*
  Behavioural converter core with its input mux: tallies the samples
  taken from each analog input.
  Assumes select and strobe come from the sequencer on i_mclk.
*/
`timescale 1ns/100ps

module ams_core_model (
  input  wire logic        i_mclk,
  input  wire logic        i_clear,
  input  wire logic [2:0]  i_mux_sel,
  input  wire logic        i_sample_strobe,
  output logic      [15:0] o_hits [8]
);
  // One sample per rising edge, counted against the selected input
  always_ff @(posedge i_mclk) begin
    for (int c = 0; c < 8; c++) begin
      if (i_clear) begin
        o_hits[c] <= 16'h0000;
      end else if (i_sample_strobe && (i_mux_sel == c[2:0])) begin
        o_hits[c] <= o_hits[c] + 16'h0001;
      end
    end
  end
endmodule // ams_core_model

/* bench/ams_scan_sequencer_tb.sv */
/*
  Self-checking bench: serial register access, scan order, rates, pipe.
  Assumes a slow serial clock, each phase several i_mclk long.
*/
`timescale 1ns/100ps

module ams_scan_sequencer_tb;
  import ams_pkg::*;
  localparam int W = 840; // Tally window, divisible by every count
  logic i_mclk = 0, i_sys_rst = 1, i_cfg_cs_n = 1, i_cfg_sclk = 0, i_cfg_sdi = 0;
  logic o_cfg_sdo, o_cfg_sdo_oe_n, o_sample_strobe, o_scan_start, o_data_valid;
  logic [2:0] o_mux_sel, o_data_chan;
  logic [3:0] o_rate_div;
  logic [15:0] hits [8];
  logic [2:0] hist [28];
  logic [7:0] rd;
  logic clr = 1;
  int errors = 0, checks = 0, fill = 0;

  always #5 i_mclk = ~i_mclk;

  ams_scan_sequencer ams_scan_sequencer_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_cfg_cs_n(i_cfg_cs_n), .i_cfg_sclk(i_cfg_sclk), .i_cfg_sdi(i_cfg_sdi),
    .o_cfg_sdo(o_cfg_sdo), .o_cfg_sdo_oe_n(o_cfg_sdo_oe_n), .o_mux_sel(o_mux_sel),
    .o_sample_strobe(o_sample_strobe), .o_scan_start(o_scan_start), .o_rate_div(o_rate_div),
    .o_data_chan(o_data_chan), .o_data_valid(o_data_valid));

  ams_core_model ams_core_model_i (.i_mclk(i_mclk), .i_clear(clr), .i_mux_sel(o_mux_sel),
    .i_sample_strobe(o_sample_strobe), .o_hits(hits));

  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Automatic: the pipe monitor calls it alongside the main sequence
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // One 16-bit frame, MSB first; sdo sampled late in the low phase
  task xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd);
    logic [15:0] f;
    f = {rw, a, wd};
    tick(1);
    i_cfg_cs_n <= 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      i_cfg_sclk <= 1'b0;
      i_cfg_sdi <= f[i];
      tick(6);
      #1;
      if (i < 8) rd[i] = o_cfg_sdo;
      if (i == 7) chk({15'h0, o_cfg_sdo_oe_n}, {15'h0, ~rw}); // Drives only in read data
      tick(1);
      i_cfg_sclk <= 1'b1;
      tick(7);
    end
    i_cfg_sclk <= 1'b0;
    i_cfg_sdi <= ~f[0]; // Idle line must not echo the last bit
    tick(6);
    i_cfg_cs_n <= 1'b1;
    tick(8);
  endtask

  task rd_chk(input logic [6:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk({8'h00, rd}, {8'h00, e});
  endtask

  task wait_start;
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge i_mclk);
      #1;
      if (o_scan_start === 1'b1) break;
    end
    if (k == 20) begin
      errors++;
      $display("Error at %0t: no scan start", $time);
      final_report;
    end
  endtask

  // Two scans of the list, then per-input sample tallies over W cycles
  task scan_chk(input logic [23:0] lst, input int n);
    int lsb [8] = '{0, 6, 12, 18, 21, 15, 9, 3};
    int e;
    wait_start();
    wait_start(); // Second start is surely past the adoption boundary
    for (int i = 0; i < 2 * n + 1; i++) begin
      chk({13'h0, o_mux_sel}, {13'h0, lst[lsb[i % n] +: 3]});
      chk({15'h0, o_scan_start}, {15'h0, (i % n) == 0});
      @(posedge i_mclk);
      #1;
    end
    chk({12'h0, o_rate_div}, n[15:0]);
    @(posedge i_mclk);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    tick(W);
    #1;
    for (int c = 0; c < 8; c++) begin
      e = 0;
      for (int j = 0; j < n; j++) if (lst[lsb[j] +: 3] == c) e += W / n;
      chk(hits[c], e[15:0]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Pipe monitor: output channel is the selection of 28 cycles before
  always @(posedge i_mclk) begin
    if (i_sys_rst) fill <= 0;
    else if (fill < 40) fill <= fill + 1;
    if (fill > 30 && o_data_valid === 1'b1) chk({13'h0, o_data_chan}, {13'h0, hist[27]});
    if (fill > 2) chk({15'h0, o_sample_strobe}, 16'h0001);
    if (fill > 2) chk({15'h0, o_data_valid}, {15'h0, fill > 28});
    for (int j = 27; j > 0; j--) hist[j] <= hist[j - 1];
    hist[0] <= o_mux_sel;
  end

  initial begin
    tick(16);
    i_sys_rst <= 1'b0;
    tick(4);
    rd_chk(ADDR_CHAN_COUNT, 8'h00);
    rd_chk(ADDR_SCAN_ORDER_LOW, 8'h78);
    rd_chk(ADDR_SCAN_ORDER_MID, 8'hAC);
    rd_chk(ADDR_SCAN_ORDER_HI, 8'h8E);
    rd_chk(7'h02, 8'h00);
    scan_chk(24'h8EAC78, 8);
    // Order 0 2 4 6 1 3 5 7 with four in use; the rest ignored
    xfer(1'b0, ADDR_SCAN_ORDER_HI, 8'h39);
    xfer(1'b0, ADDR_SCAN_ORDER_MID, 8'hCA);
    xfer(1'b0, ADDR_SCAN_ORDER_LOW, 8'hB8);
    xfer(1'b0, ADDR_CHAN_COUNT, 8'h04);
    xfer(1'b0, 7'h02, 8'h55);
    rd_chk(ADDR_SCAN_ORDER_MID, 8'hCA);
    rd_chk(ADDR_CHAN_COUNT, 8'h04);
    rd_chk(7'h02, 8'h00);
    scan_chk(24'h39CAB8, 4);
    // Reversed order, then every remaining count code
    xfer(1'b0, ADDR_SCAN_ORDER_HI, 8'h71);
    xfer(1'b0, ADDR_SCAN_ORDER_MID, 8'h53);
    xfer(1'b0, ADDR_SCAN_ORDER_LOW, 8'h87);
    xfer(1'b0, ADDR_CHAN_COUNT, 8'h01);
    scan_chk(24'h715387, 1);
    for (int n = 2; n < 8; n++) begin
      xfer(1'b0, ADDR_CHAN_COUNT, n[7:0]);
      scan_chk(24'h715387, n);
    end
    final_report;
  end
endmodule // ams_scan_sequencer_tb
